// ### src/timing_pin_pkg.sv
package timing_pin_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [7:0] IDX_PIN_CFG = 8'h02;
  localparam logic [7:0] IDX_SEL_CTRL = 8'h0B;
  localparam logic [7:0] IDX_PIN1_ENA = 8'h4F;
  localparam logic [7:0] IDX_STATUS = 8'h70;
  localparam logic [7:0] IDX_MASK = 8'h71;
  localparam logic [7:0] IDX_STATE = 8'h72;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 8;
  localparam int SEL_W = 5;
  localparam int CFG0_POL = 0;
  localparam int CFG0_OD = 1;
  localparam int CFG0_ENA = 2;
  localparam int CFG1_POL = 8;
  localparam int CFG1_OD = 9;
  localparam int PIN1_ENA_BIT = 6;
  localparam int EVT_W = 4;
  localparam int EVT_DATA_A = 0;
  localparam int EVT_DATA_B = 1;
  localparam int EVT_SAMPLE = 2;
  localparam int EVT_HALF = 3;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [15:0] SEL_CTRL_RST = 16'h0000;
  localparam logic [15:0] PIN_CFG_RST = 16'h0000;
  localparam logic PIN1_ENA_RST = 1'h0;
  localparam logic [EVT_W-1:0] MASK_RST = 4'h0;

  // ==========================================================
  // Source selector codes
  // ==========================================================
  localparam logic [4:0] SRC_IRQ = 5'h01;
  localparam logic [4:0] SRC_SAMPLE = 5'h02;
  localparam logic [4:0] SRC_LED_A = 5'h05;
  localparam logic [4:0] SRC_LED_B = 5'h06;
  localparam logic [4:0] SRC_LED_AB = 5'h07;
  localparam logic [4:0] SRC_DATA_A = 5'h0C;
  localparam logic [4:0] SRC_DATA_B = 5'h0D;
  localparam logic [4:0] SRC_DATA_AB = 5'h0E;
  localparam logic [4:0] SRC_HALF = 5'h0F;
  localparam logic [4:0] SRC_ZERO = 5'h10;
  localparam logic [4:0] SRC_ONE = 5'h11;
  localparam logic [4:0] SRC_OSC = 5'h13;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic ledA;
    logic ledB;
    logic dataA;
    logic dataB;
    logic sampleStart;
    logic sampleEnd;
    logic sampleDone;
  } timing_in_t;

  typedef struct packed {
    logic enable;
    logic openDrain;
    logic activeLow;
  } pin_cfg_t;

endpackage : timing_pin_pkg

// ### src/pin_drive_stage.sv
`timescale 1ns/100ps
module pin_drive_stage (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Selection
  input wire logic [31:0] srcVec,
  input wire logic [4:0] sel,
  input wire timing_pin_pkg::pin_cfg_t cfg,
  // Pin
  output logic pinOut,
  output logic pinOe
);

  // ==========================================================
  // Selection and drive
  // ==========================================================
  // Codes with no source read zero, so the pin rests inactive
  wire logic raw = srcVec[sel]; // see RULE15
  wire logic out_d = raw ^ cfg.activeLow; // see RULE14
  wire logic oe_d = cfg.enable & (~cfg.openDrain | raw); // see RULE14

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinOut <= 1'h0;
      pinOe <= 1'h0;
    end else begin
      pinOut <= out_d; // see RULE15
      pinOe <= oe_d;
    end
  end

endmodule : pin_drive_stage

// ### src/timing_signal_pin_select.sv
`timescale 1ns/100ps
// What this block does
// RULE1: two independent five-bit selectors in the timing control register
// RULE2: code 05h drives a copy of first-slot LED pulses
// RULE3: code 06h second-slot LED pulses, 07h both slots' pulses
// RULE4: codes 0Ch, 0Dh, 0Eh give data-written for slot A, B, either
// RULE5: data-written rises at slot end, falls when next sample begins
// RULE6: code 0Fh gives a signal toggling once per sample
// RULE7: half-rate signal starts low on entering normal mode
// RULE8: code 10h forces a constant low
// RULE9: code 11h forces a constant high
// RULE10: code 13h copies the 32 kHz oscillator
// RULE11: bits 12:8 steer pin 1, bits 4:0 steer pin 0
// RULE12: code 01h routes the interrupt output to the pin
// RULE13: code 02h marks first enabled slot start to last slot end
// RULE14: per-pin polarity bit and always-drive or drive-when-asserted bit
// RULE15: undefined codes give inactive level; new code acts next edge
module timing_signal_pin_select #(
  parameter int ADDR_W = 9
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave, byte address
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Timing core, same clock
  input wire timing_pin_pkg::timing_in_t timing,
  input wire logic intLevel,
  input wire logic normalMode,
  // 32 kHz oscillator, asynchronous
  input wire logic osc32k,
  // Output pins
  input wire logic [1:0] pinIn,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr
    $error("ADDR_W must lie between 9 and 16");
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    logic [ADDR_W-1:0] b;
    b = ADDR_W'({idx, 2'b00});
    hit = (a == b);
  endfunction : hit

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    merge = r;
  endfunction : merge

  // ==========================================================
  // Bus handshake
  // ==========================================================
  logic wait_q;
  wire logic req = read | write;
  wire logic accept = req & ~wait_q;
  wire logic wrAcc = write & ~wait_q;
  wire logic rdAcc = read & ~wait_q;

  // One cycle of wait, then the request completes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'h1;
    end else if (accept) begin
      wait_q <= 1'h1;
    end else if (req) begin
      wait_q <= 1'h0;
    end
  end

  assign waitrequest = wait_q;

  wire logic hitCfg = hit(address, timing_pin_pkg::IDX_PIN_CFG);
  wire logic hitSel = hit(address, timing_pin_pkg::IDX_SEL_CTRL);
  wire logic hitEna = hit(address, timing_pin_pkg::IDX_PIN1_ENA);
  wire logic hitSts = hit(address, timing_pin_pkg::IDX_STATUS);
  wire logic hitMsk = hit(address, timing_pin_pkg::IDX_MASK);
  wire logic hitSta = hit(address, timing_pin_pkg::IDX_STATE);

  // ==========================================================
  // Software registers
  // ==========================================================
  logic [15:0] selCtrl_q;
  logic [15:0] pinCfg_q;
  logic pin1Ena_q;
  logic [timing_pin_pkg::EVT_W-1:0] mask_q;

  wire logic [15:0] selCtrl_d = merge(selCtrl_q, writedata, byteenable);
  wire logic [15:0] pinCfg_d = merge(pinCfg_q, writedata, byteenable);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      selCtrl_q <= timing_pin_pkg::SEL_CTRL_RST;
      pinCfg_q <= timing_pin_pkg::PIN_CFG_RST;
      pin1Ena_q <= timing_pin_pkg::PIN1_ENA_RST;
      mask_q <= timing_pin_pkg::MASK_RST;
    end else if (wrAcc) begin
      if (hitSel) begin
        selCtrl_q <= selCtrl_d; // see RULE1
      end
      if (hitCfg) begin
        pinCfg_q <= pinCfg_d;
      end
      if (hitEna && byteenable[0]) begin
        pin1Ena_q <= writedata[timing_pin_pkg::PIN1_ENA_BIT];
      end
      if (hitMsk && byteenable[0]) begin
        mask_q <= writedata[timing_pin_pkg::EVT_W-1:0];
      end
    end
  end

  // ==========================================================
  // Field extraction
  // ==========================================================
  localparam int S0 = timing_pin_pkg::SEL0_LSB;
  localparam int S1 = timing_pin_pkg::SEL1_LSB;
  localparam int SW = timing_pin_pkg::SEL_W;

  wire logic [SW-1:0] sel0 = selCtrl_q[S0 +: SW]; // see RULE11
  wire logic [SW-1:0] sel1 = selCtrl_q[S1 +: SW]; // see RULE11
  wire logic [15:0] selRead = {3'h0, sel1, 3'h0, sel0};

  timing_pin_pkg::pin_cfg_t cfg0;
  timing_pin_pkg::pin_cfg_t cfg1;

  // Independent polarity and drive mode for each pin
  assign cfg0.enable = pinCfg_q[timing_pin_pkg::CFG0_ENA];
  assign cfg0.openDrain = pinCfg_q[timing_pin_pkg::CFG0_OD]; // see RULE14
  assign cfg0.activeLow = pinCfg_q[timing_pin_pkg::CFG0_POL]; // see RULE14
  assign cfg1.enable = pin1Ena_q;
  assign cfg1.openDrain = pinCfg_q[timing_pin_pkg::CFG1_OD]; // see RULE14
  assign cfg1.activeLow = pinCfg_q[timing_pin_pkg::CFG1_POL]; // see RULE14

  wire logic [15:0] cfgMaskBits =
    (16'h0001 << timing_pin_pkg::CFG0_POL) |
    (16'h0001 << timing_pin_pkg::CFG0_OD) |
    (16'h0001 << timing_pin_pkg::CFG0_ENA) |
    (16'h0001 << timing_pin_pkg::CFG1_POL) |
    (16'h0001 << timing_pin_pkg::CFG1_OD);
  wire logic [15:0] cfgRead = pinCfg_q & cfgMaskBits;

  // ==========================================================
  // Synchronisers for asynchronous inputs
  // ==========================================================
  logic oscMeta_q;
  logic oscSync_q;
  logic [1:0] pinMeta_q;
  logic [1:0] pinSync_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oscMeta_q <= 1'h0;
      oscSync_q <= 1'h0;
      pinMeta_q <= 2'h0;
      pinSync_q <= 2'h0;
    end else begin
      oscMeta_q <= osc32k;
      oscSync_q <= oscMeta_q;
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // ==========================================================
  // Derived timing signals
  // ==========================================================
  logic dataA_q;
  logic dataB_q;
  logic sampleAct_q;
  logic halfRate_q;
  logic normalPrev_q;

  wire logic enterNormal = normalMode & ~normalPrev_q;

  // Set wins so a slot end in the start cycle is kept
  wire logic dataA_d = timing.dataA |
                       (dataA_q & ~timing.sampleStart); // see RULE5
  wire logic dataB_d = timing.dataB |
                       (dataB_q & ~timing.sampleStart); // see RULE5
  wire logic sampleAct_d = timing.sampleStart |
                           (sampleAct_q & ~timing.sampleEnd); // see RULE13

  logic halfRate_d;
  always_comb begin
    halfRate_d = halfRate_q;
    if (enterNormal) begin
      halfRate_d = 1'h0; // see RULE7
    end else if (normalMode && timing.sampleDone) begin
      halfRate_d = ~halfRate_q; // see RULE6
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataA_q <= 1'h0;
      dataB_q <= 1'h0;
      sampleAct_q <= 1'h0;
      halfRate_q <= 1'h0;
      normalPrev_q <= 1'h0;
    end else begin
      dataA_q <= dataA_d;
      dataB_q <= dataB_d;
      sampleAct_q <= sampleAct_d;
      halfRate_q <= halfRate_d;
      normalPrev_q <= normalMode;
    end
  end

  // ==========================================================
  // Source table, indexed by selector code
  // ==========================================================
  logic [31:0] srcVec;
  always_comb begin
    srcVec = 32'h0000_0000;
    srcVec[timing_pin_pkg::SRC_IRQ] = intLevel; // see RULE12
    srcVec[timing_pin_pkg::SRC_SAMPLE] = sampleAct_q; // see RULE13
    srcVec[timing_pin_pkg::SRC_LED_A] = timing.ledA; // see RULE2
    srcVec[timing_pin_pkg::SRC_LED_B] = timing.ledB; // see RULE3
    srcVec[timing_pin_pkg::SRC_LED_AB] =
      timing.ledA | timing.ledB; // see RULE3
    srcVec[timing_pin_pkg::SRC_DATA_A] = dataA_q; // see RULE4
    srcVec[timing_pin_pkg::SRC_DATA_B] = dataB_q; // see RULE4
    srcVec[timing_pin_pkg::SRC_DATA_AB] = dataA_q | dataB_q; // see RULE4
    srcVec[timing_pin_pkg::SRC_HALF] = halfRate_q; // see RULE6
    srcVec[timing_pin_pkg::SRC_ZERO] = 1'h0; // see RULE8
    srcVec[timing_pin_pkg::SRC_ONE] = 1'h1; // see RULE9
    srcVec[timing_pin_pkg::SRC_OSC] = oscSync_q; // see RULE10
  end

  // ==========================================================
  // Pin stages
  // ==========================================================
  wire logic [SW-1:0] selArr [2];
  timing_pin_pkg::pin_cfg_t cfgArr [2];
  assign selArr[0] = sel0;
  assign selArr[1] = sel1;
  assign cfgArr[0] = cfg0;
  assign cfgArr[1] = cfg1;

  for (genvar p = 0; p < 2; p++) begin : g_pin
    pin_drive_stage u_stage (
      .sys_clk(sys_clk),
      .rst(rst),
      .srcVec(srcVec),
      .sel(selArr[p]), // see RULE1
      .cfg(cfgArr[p]),
      .pinOut(pinOut[p]),
      .pinOe(pinOe[p])
    );
  end

  // ==========================================================
  // Event status and interrupt
  // ==========================================================
  logic [timing_pin_pkg::EVT_W-1:0] status_q;
  logic [timing_pin_pkg::EVT_W-1:0] evt;

  always_comb begin
    evt = '0;
    evt[timing_pin_pkg::EVT_DATA_A] = timing.dataA;
    evt[timing_pin_pkg::EVT_DATA_B] = timing.dataB;
    evt[timing_pin_pkg::EVT_SAMPLE] = timing.sampleDone;
    evt[timing_pin_pkg::EVT_HALF] = halfRate_d ^ halfRate_q;
  end

  wire logic stsClr = rdAcc & hitSts;
  // Only bits already reported are cleared, so a late event survives
  wire logic [timing_pin_pkg::EVT_W-1:0] stsTaken =
    {timing_pin_pkg::EVT_W{stsClr}} & readdata[timing_pin_pkg::EVT_W-1:0];
  wire logic [timing_pin_pkg::EVT_W-1:0] status_d =
    evt | (status_q & ~stsTaken);
  wire logic irq_d = |(status_d & mask_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
      irq <= 1'h0;
    end else begin
      status_q <= status_d;
      irq <= irq_d;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  wire logic [15:0] stateRead = {
    10'h000, pinSync_q, halfRate_q, sampleAct_q, dataB_q, dataA_q
  };

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitSel) begin
      rdMux[15:0] = selRead;
    end else if (hitCfg) begin
      rdMux[15:0] = cfgRead;
    end else if (hitEna) begin
      rdMux[timing_pin_pkg::PIN1_ENA_BIT] = pin1Ena_q;
    end else if (hitSts) begin
      rdMux[timing_pin_pkg::EVT_W-1:0] = status_q;
    end else if (hitMsk) begin
      rdMux[timing_pin_pkg::EVT_W-1:0] = mask_q;
    end else if (hitSta) begin
      rdMux[15:0] = stateRead;
    end
  end

  // Loaded as waitrequest falls so data stands at the accept edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && wait_q) begin
      readdata <= rdMux;
    end
  end

endmodule : timing_signal_pin_select

// ### tb/timing_signal_pin_select_asserts.sv
`timescale 1ns/100ps
module timing_signal_pin_select_asserts #(
  parameter int ADDR_W = 9
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // Sources and pins
  input wire timing_pin_pkg::timing_in_t timing,
  input wire logic osc32k,
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe
);
  // ==========================================================
  // Shadow of selector and pin settings
  logic [15:0] selQ;
  logic [15:0] cfgQ;
  logic enaQ;
  logic take;
  logic hitSel;
  logic hitCfg;
  logic hitEna;
  logic undef0;
  assign take = write && !waitrequest;
  assign hitSel = address[ADDR_W-1:2] ==
    (ADDR_W-2)'(timing_pin_pkg::IDX_SEL_CTRL);
  assign hitCfg = address[ADDR_W-1:2] ==
    (ADDR_W-2)'(timing_pin_pkg::IDX_PIN_CFG);
  assign hitEna = address[ADDR_W-1:2] ==
    (ADDR_W-2)'(timing_pin_pkg::IDX_PIN1_ENA);
  assign undef0 = !(selQ[4:0] inside {5'h01, 5'h02, 5'h05, 5'h06, 5'h07,
    5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h13});

  function automatic logic [15:0] merge(logic [15:0] o, logic [31:0] d,
    logic [3:0] be);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction : merge

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      selQ <= 16'h0000;
      cfgQ <= 16'h0000;
      enaQ <= 1'h0;
    end else if (take) begin
      if (hitSel) selQ <= merge(selQ, writedata, byteenable);
      if (hitCfg) cfgQ <= merge(cfgQ, writedata, byteenable);
      if (hitEna && byteenable[0]) enaQ <= writedata[6];
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_bus_one_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait cycle");
  a_led_a_copy: assert property (
    $past(selQ[4:0]) == 5'h05 |->
      pinOut[0] == ($past(timing.ledA) ^ $past(cfgQ[0])))
    else $error("pin 0 does not copy slot A pulses");
  a_led_b_pin1: assert property (
    $past(selQ[12:8]) == 5'h06 |->
      pinOut[1] == ($past(timing.ledB) ^ $past(cfgQ[8])))
    else $error("pin 1 does not copy slot B pulses");
  a_data_set: assert property (
    $past(timing.dataA, 2) && $past(selQ[4:0]) == 5'h0C |->
      pinOut[0] != $past(cfgQ[0]))
    else $error("slot A written flag not raised");
  a_data_clear: assert property (
    $past(timing.sampleStart, 2) && !$past(timing.dataB, 2) &&
      $past(selQ[12:8]) == 5'h0D |-> pinOut[1] == $past(cfgQ[8]))
    else $error("slot B written flag not cleared");
  a_const_high: assert property (
    $past(selQ[12:8]) == 5'h11 |-> pinOut[1] != $past(cfgQ[8]))
    else $error("pin 1 not at constant high");
  a_osc_copy: assert property (
    $past(selQ[12:8]) == 5'h13 |->
      pinOut[1] == ($past(osc32k, 3) ^ $past(cfgQ[8])))
    else $error("pin 1 does not copy the oscillator");
  a_undef_idle: assert property (
    $past(undef0) |-> pinOut[0] == $past(cfgQ[0]))
    else $error("undefined code not at inactive level");
  a_oe_pin0: assert property (
    pinOe[0] == ($past(cfgQ[2]) &&
      (!$past(cfgQ[1]) || pinOut[0] != $past(cfgQ[0]))))
    else $error("pin 0 enable wrong for drive mode");
  a_oe_pin1: assert property (
    pinOe[1] == ($past(enaQ) &&
      (!$past(cfgQ[9]) || pinOut[1] != $past(cfgQ[8]))))
    else $error("pin 1 enable wrong for drive mode");
endmodule : timing_signal_pin_select_asserts

bind timing_signal_pin_select timing_signal_pin_select_asserts #(
  .ADDR_W(ADDR_W)
) chk_u (.sys_clk, .rst, .address, .read, .write, .writedata, .byteenable,
  .waitrequest, .timing, .osc32k, .pinOut, .pinOe);

// ### tb/timing_core_model.sv
`timescale 1ns/100ps
module timing_core_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Mode
  input wire logic normalMode,
  // Sources
  output timing_pin_pkg::timing_in_t timing,
  output logic osc32k
);
  // ==========================================================
  // Forty-cycle sample, held at its start while in standby
  logic [5:0] cntQ;

  function automatic logic on(logic [5:0] c, logic [5:0] lo, logic [5:0] hi);
    return c >= lo && c <= hi;
  endfunction : on

  initial begin
    osc32k = 1'b0;
    // Kept off the clock edges so sampling is not a race
    #2;
    forever #15625 osc32k = ~osc32k;
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst || !normalMode) cntQ <= 6'h00;
    else cntQ <= (cntQ == 6'h27) ? 6'h00 : cntQ + 6'h01;
  end

  assign timing = {on(cntQ, 6'h04, 6'h05), on(cntQ, 6'h0C, 6'h0F),
    on(cntQ, 6'h08, 6'h08), on(cntQ, 6'h14, 6'h14), on(cntQ, 6'h02, 6'h02),
    on(cntQ, 6'h16, 6'h16), on(cntQ, 6'h18, 6'h18)};
endmodule : timing_core_model

// ### tb/timing_signal_pin_select_bench.sv
`timescale 1ns/100ps
module timing_signal_pin_select_bench;
  logic sys_clk;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [8:0] address = 9'h000;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic intLevel = 1'b0;
  logic normalMode = 1'b0;
  logic [1:0] pinIn = 2'h3;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic osc32k;
  logic [1:0] pinOut;
  logic [1:0] pinOe;
  timing_pin_pkg::timing_in_t timing;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;

  timing_signal_pin_select dut_u (.sys_clk, .rst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .timing, .intLevel,
    .normalMode, .osc32k, .pinIn, .pinOut, .pinOe, .irq);
  timing_core_model core_u (.sys_clk, .rst, .normalMode, .timing, .osc32k);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Released pins are pulled up
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    pinIn <= (pinOut & pinOe) | ~pinOe;
    if (cycles > 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic bus(logic wr, logic [7:0] idx, logic [31:0] wd,
    output logic [31:0] q);
    @(posedge sys_clk);
    address <= {idx[6:0], 2'h0};
    write <= wr;
    read <= !wr;
    writedata <= wd;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wr(logic [7:0] idx, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic chk(string what, logic [7:0] idx, logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    cmp(what, exp, q);
  endtask : chk

  task automatic setSel(logic [4:0] s1, logic [4:0] s0);
    wr(timing_pin_pkg::IDX_SEL_CTRL, {19'h0, s1, 3'h0, s0});
  endtask : setSel

  task automatic finish_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    cmp("pinOe", 32'h0, 32'(pinOe));
    chk("selector", timing_pin_pkg::IDX_SEL_CTRL, 32'h0);
    chk("pin cfg", timing_pin_pkg::IDX_PIN_CFG, 32'h0);
    chk("state", timing_pin_pkg::IDX_STATE, 32'h30);
    wr(8'h30, 32'hFFFF);
    chk("unmapped", 8'h30, 32'h0);
    setSel(5'h13, 5'h11);
    chk("selector", timing_pin_pkg::IDX_SEL_CTRL, 32'h1311);
  endtask : test_reset

  task automatic test_codes;
    logic [4:0] s1 [4] = '{5'h11, 5'h10, 5'h11, 5'h12};
    logic [4:0] s0 [4] = '{5'h10, 5'h11, 5'h03, 5'h1F};
    logic [1:0] raw;
    wr(timing_pin_pkg::IDX_PIN1_ENA, 32'h40);
    for (int m = 0; m < 4; m++) begin
      wr(timing_pin_pkg::IDX_PIN_CFG,
        {22'h0, m[1], m[0], 5'h0, 1'b1, m[1], m[0]});
      for (int i = 0; i < 4; i++) begin
        setSel(s1[i], s0[i]);
        repeat (2) @(posedge sys_clk);
        raw = {s1[i] == 5'h11, s0[i] == 5'h11};
        cmp("pinOut", 32'(raw ^ {2{m[0]}}), 32'(pinOut));
        cmp("pinOe", {30'h0, ~{2{m[1]}} | raw}, 32'(pinOe));
      end
    end
  endtask : test_codes

  task automatic test_sources;
    logic [4:0] s1 [5] = '{5'h06, 5'h07, 5'h0D, 5'h0E, 5'h02};
    logic [4:0] s0 [5] = '{5'h05, 5'h07, 5'h0C, 5'h0E, 5'h02};
    int e1 [5] = '{8, 12, 44, 68, 40};
    int e0 [5] = '{4, 12, 68, 68, 40};
    int c0;
    int c1;
    wr(timing_pin_pkg::IDX_PIN_CFG, 32'h4);
    normalMode <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      setSel(s1[i], s0[i]);
      repeat (3) @(posedge sys_clk);
      c0 = 0;
      c1 = 0;
      repeat (80) begin
        @(posedge sys_clk);
        c0 += int'(pinOut[0] === 1'b1);
        c1 += int'(pinOut[1] === 1'b1);
      end
      cmp("pin0 high", e0[i], c0);
      cmp("pin1 high", e1[i], c1);
    end
  endtask : test_sources

  task automatic test_half;
    normalMode <= 1'b0;
    setSel(5'h0F, 5'h0F);
    for (int k = 0; k < 2; k++) begin
      repeat (5) @(posedge sys_clk);
      normalMode <= 1'b1;
      repeat (10) @(posedge sys_clk);
      cmp("half start", 32'h0, 32'(pinOut));
      repeat (25) @(posedge sys_clk);
      cmp("half first", 32'h3, 32'(pinOut));
      repeat (40) @(posedge sys_clk);
      cmp("half second", 32'h0, 32'(pinOut));
      repeat (35) @(posedge sys_clk);
      cmp("half third", 32'h3, 32'(pinOut));
      normalMode <= 1'b0;
    end
  endtask : test_half

  task automatic test_irq;
    logic [31:0] q;
    wr(timing_pin_pkg::IDX_MASK, 32'h0);
    bus(1'b0, timing_pin_pkg::IDX_STATUS, 32'h0, q);
    normalMode <= 1'b1;
    repeat (45) @(posedge sys_clk);
    normalMode <= 1'b0;
    repeat (3) @(posedge sys_clk);
    cmp("irq masked", 32'h0, 32'(irq));
    wr(timing_pin_pkg::IDX_MASK, 32'h4);
    repeat (2) @(posedge sys_clk);
    cmp("irq", 32'h1, 32'(irq));
    chk("status", timing_pin_pkg::IDX_STATUS, 32'hF);
    repeat (2) @(posedge sys_clk);
    cmp("irq cleared", 32'h0, 32'(irq));
    chk("status", timing_pin_pkg::IDX_STATUS, 32'h0);
    setSel(5'h01, 5'h01);
    intLevel <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmp("int pins", 32'h3, 32'(pinOut));
    intLevel <= 1'b0;
    repeat (3) @(posedge sys_clk);
    cmp("int pins", 32'h0, 32'(pinOut));
  endtask : test_irq

  task automatic test_osc;
    wr(timing_pin_pkg::IDX_PIN_CFG, 32'h104);
    setSel(5'h13, 5'h13);
    for (int k = 0; k < 2; k++) begin
      @(osc32k);
      repeat (5) @(posedge sys_clk);
      cmp("osc copy", 32'({~osc32k, osc32k}), 32'(pinOut));
    end
  endtask : test_osc

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_codes();
    test_sources();
    test_half();
    test_irq();
    test_osc();
    finish_test();
  end
endmodule : timing_signal_pin_select_bench
